// [hdl/disc_adapter_regs.vh]
// Constants for the disc adapter signalling block
`ifndef DISC_ADAPTER_REGS_VH
`define DISC_ADAPTER_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS   20
`define STROBE_NS       70
`define STROBE_CYC      ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ABORT_NS        50
`define ABORT_CYC       ((`ABORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYC        8
`define CNT_W           4

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_W          5
`define OFS_CTRL        5'h00
`define OFS_STAT        5'h04
`define OFS_MASK        5'h08
`define OFS_DATA        5'h0c
`define OFS_CMD         5'h10
`define OFS_STATE       5'h14

// ----------------------------------------
// Field layouts
// ----------------------------------------
`define WORD_W          16
`define CTRL_W          6
`define CTRL_MAINT      0
`define CTRL_CS_LOAD    1
`define CTRL_PRIMARY    2
`define CTRL_XFER       3
`define CTRL_CMP_EQ     4
`define CTRL_CMP_NE     5
`define STAT_W          9
`define ST_CMD_EARLY    0
`define ST_MISSED_WIN   1
`define ST_TRACK_BND    2
`define ST_RW_TERM      3
`define ST_LOST_DATA    4
`define ST_NO_SYNC      5
`define ST_BURST_CHK    6
`define ST_END_CYL      7
`define ST_SEEK_INC     8
`define CMD_BOOT        0
`define CMD_REQ_DATA    1
`define CMD_REQ_STATUS  2
`define CTRL_RST        6'h00
`define STAT_RST        9'h000
`define MASK_RST        9'h000

`endif

// [hdl/pulse_timer.v]
// Retriggerable fixed-width pulse generator
`timescale 1ns/1ns
`default_nettype none

module pulse_timer #(
  parameter [3:0] LEN = 4'h1
) (
  input  wire       clk_i,
  input  wire       rstn_i,
  input  wire       start_i,
  output reg        pulse_o
);

  reg [3:0] cnt_q;

  // Load on start, count down to zero
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q   <= 4'h0;
      pulse_o <= 1'b0;
    end else if (start_i) begin
      cnt_q   <= LEN - 4'h1;
      pulse_o <= 1'b1;
    end else if (cnt_q != 4'h0) begin
      cnt_q   <= cnt_q - 4'h1;
      pulse_o <= 1'b1;
    end else begin
      pulse_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [hdl/disc_adapter.v]
// Disc adapter to shared-processor signalling with Avalon-MM registers
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "disc_adapter_regs.vh"

// Summary of operation
// RL1: Each data word written to the extended register while no strobe is running is announced by one strobe of 80 ns.
// RL2: Transfer end rises on command early, missed window, track boundary, read/write end, lost data or no sync.
// RL3: In a control-store load in normal mode a missed window also raises transfer end.
// RL4: Transfer end is a level that falls only after its causing status is cleared.
// RL5: A boot request runs an init sequence whose trailing edge sets processor 4 busy.
// RL6: With primary boot select the processor forces its control-store address on its first cycle.
// RL7: The abort mask hides a maintenance-mode burst check abort from the halt alarm.
// RL8: The abort mask rises 60 ns before the abort pulse and lasts 60 ns.
// RL9: The slice request rises when the adapter is ready to move data or status.
// RL10: A data slice request drops once the execute phase is active.
// RL11: A status slice request holds until a request-status instruction executes.
// RL12: Transfer exit also ends a transfer on compare-equal or compare-unequal commands.
// RL13: The abort pulse is at least 50 ns wide and fires on load-time burst, cylinder, sync or seek errors.
// RL14: The slice request is a registered level on the shared clock.
module disc_adapter (
  input  wire                 CLK_I,
  input  wire                 RSTN_I,
  input  wire [`ADDR_W-1:0]   AVS_ADDRESS_I,
  input  wire                 AVS_READ_I,
  input  wire                 AVS_WRITE_I,
  input  wire [31:0]          AVS_WRITEDATA_I,
  input  wire [3:0]           AVS_BYTEENABLE_I,
  output reg  [31:0]          AVS_READDATA_O,
  output reg                  AVS_WAITREQUEST_O,
  output reg                  IRQ_O,
  input  wire [`STAT_W-1:0]   STAT_EVT_I,
  input  wire                 EXECUTE_PHASE_I,
  input  wire                 REQ_STATUS_DONE_I,
  input  wire                 CMP_EQUAL_I,
  output reg  [`WORD_W-1:0]   EXT_DATA_O,
  output wire                 DISC_WORD_STROBE_O,
  output reg                  TRANSFER_END_O,
  output reg                  XFER_EXIT_O,
  output wire                 INIT_SEQUENCE_O,
  output reg                  SET_BUSY4_O,
  output reg                  BOOT_PRIMARY_O,
  output reg                  RESTART_ABORT_MASK_O,
  output reg                  RESTART_ABORT_PULSE_O,
  output reg                  SLICE_REQ_O
);

  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  localparam [2:0] AB_IDLE  = 3'h1;
  localparam [2:0] AB_LEAD  = 3'h2;
  localparam [2:0] AB_PULSE = 3'h4;

  localparam integer STROBE_NUM = `STROBE_CYC;
  localparam integer ABORT_NUM  = `ABORT_CYC;
  localparam integer INIT_NUM   = `INIT_CYC;
  localparam [3:0]   STROBE_LEN = STROBE_NUM[3:0];
  localparam [3:0]   ABORT_LEN  = ABORT_NUM[3:0];
  localparam [3:0]   INIT_LEN   = INIT_NUM[3:0];

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [`CTRL_W-1:0]  ctrl_q;
  reg  [`CTRL_W-1:0]  ctrl_d;
  reg  [`STAT_W-1:0]  stat_q;
  reg  [`STAT_W-1:0]  stat_d;
  reg  [`STAT_W-1:0]  mask_q;
  reg  [`STAT_W-1:0]  mask_d;
  reg  [31:0]         rdata_d;
  reg  [2:0]          ab_q;
  reg  [2:0]          ab_d;
  reg  [`CNT_W-1:0]   ab_cnt_q;
  reg  [`CNT_W-1:0]   ab_cnt_d;
  reg                 ab_hide_q;
  reg                 ab_hide_d;
  reg                 req_data_q;
  reg                 req_stat_q;
  reg                 init_dly_q;
  reg                 strobe_go_q;
  reg                 boot_go_q;
  wire [31:0]         wmask;
  wire                wr_en;
  wire                rd_en;
  wire                end_d;
  wire                cmp_hit;
  wire                abort_trig;
  wire                wr_ctrl;
  wire                wr_cmd;

  // ----------------------------------------
  // Avalon slave handshake
  // ----------------------------------------
  // Byte-lane write mask
  assign wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                  {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  // Write completes on the edge where waitrequest is low, read data is captured on the edge before, while it is high
  assign wr_en   = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
  assign rd_en   = AVS_READ_I & AVS_WAITREQUEST_O;
  assign wr_ctrl = wr_en & (AVS_ADDRESS_I == `OFS_CTRL);
  assign wr_cmd  = wr_en & (AVS_ADDRESS_I == `OFS_CMD);

  // Waitrequest drops for one cycle per request
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O);
      if (rd_en) begin
        AVS_READDATA_O <= rdata_d;
      end
    end
  end

  // Read mux, unmapped reads as zero
  always @* begin
    rdata_d = 32'h0000_0000;
    case (AVS_ADDRESS_I)
      `OFS_CTRL:  rdata_d[`CTRL_W-1:0] = ctrl_q;
      `OFS_STAT:  rdata_d[`STAT_W-1:0] = stat_q;
      `OFS_MASK:  rdata_d[`STAT_W-1:0] = mask_q;
      `OFS_DATA:  rdata_d[`WORD_W-1:0] = EXT_DATA_O;
      `OFS_STATE: rdata_d[7:0] = {ab_q, INIT_SEQUENCE_O, req_stat_q, req_data_q, SLICE_REQ_O, TRANSFER_END_O};
      default:    rdata_d = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Control, status and mask registers
  // ----------------------------------------
  // Compare condition for the two compare commands
  assign cmp_hit = ctrl_q[`CTRL_XFER] & ((ctrl_q[`CTRL_CMP_EQ] & CMP_EQUAL_I) |
                   (ctrl_q[`CTRL_CMP_NE] & ~CMP_EQUAL_I)); // RL12

  // Next values of control, sticky status and mask
  always @* begin
    ctrl_d = ctrl_q;
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_ctrl) begin
      ctrl_d = (ctrl_q & ~wmask[`CTRL_W-1:0]) | (AVS_WRITEDATA_I[`CTRL_W-1:0] & wmask[`CTRL_W-1:0]);
    end
    if (wr_en && AVS_ADDRESS_I == `OFS_MASK) begin
      mask_d = (mask_q & ~wmask[`STAT_W-1:0]) | (AVS_WRITEDATA_I[`STAT_W-1:0] & wmask[`STAT_W-1:0]);
    end
    if (wr_en && AVS_ADDRESS_I == `OFS_STAT) begin
      stat_d = stat_q & ~(AVS_WRITEDATA_I[`STAT_W-1:0] & wmask[`STAT_W-1:0]);
    end
    // New events win over a same-cycle clear
    stat_d = stat_d | STAT_EVT_I;
    // Exit ends the running transfer
    if (XFER_EXIT_O) begin
      ctrl_d[`CTRL_XFER] = 1'b0; // RL12
    end
  end

  // Register update
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl_q <= `CTRL_RST;
      stat_q <= `STAT_RST;
      mask_q <= `MASK_RST;
      IRQ_O  <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      IRQ_O  <= |(stat_d & mask_d);
    end
  end

  // ----------------------------------------
  // Transfer end and exit
  // ----------------------------------------
  // Level from the live status bits
  assign end_d = stat_d[`ST_CMD_EARLY] | stat_d[`ST_MISSED_WIN] | stat_d[`ST_TRACK_BND] |
                 stat_d[`ST_RW_TERM] | stat_d[`ST_LOST_DATA] | stat_d[`ST_NO_SYNC] | // RL2
                 (stat_d[`ST_MISSED_WIN] & ctrl_q[`CTRL_CS_LOAD] & ~ctrl_q[`CTRL_MAINT]); // RL3

  // Held until status is cleared
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TRANSFER_END_O <= 1'b0;
      XFER_EXIT_O    <= 1'b0;
    end else begin
      TRANSFER_END_O <= end_d; // RL4
      XFER_EXIT_O    <= end_d | cmp_hit; // RL2
    end
  end

  // ----------------------------------------
  // Data word and strobe
  // ----------------------------------------
  // Latch word, then start the strobe
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      EXT_DATA_O  <= 16'h0000;
      strobe_go_q <= 1'b0;
    end else begin
      strobe_go_q <= wr_en & (AVS_ADDRESS_I == `OFS_DATA) & AVS_BYTEENABLE_I[0];
      if (wr_en && AVS_ADDRESS_I == `OFS_DATA) begin
        EXT_DATA_O <= (EXT_DATA_O & ~wmask[`WORD_W-1:0]) | (AVS_WRITEDATA_I[`WORD_W-1:0] & wmask[`WORD_W-1:0]);
      end
    end
  end

  // Strobe after the word is stable
  pulse_timer #(
    .LEN     (STROBE_LEN)
  ) u_strobe (
    .clk_i   (CLK_I),
    .rstn_i  (RSTN_I),
    .start_i (strobe_go_q & ~DISC_WORD_STROBE_O), // RL1
    .pulse_o (DISC_WORD_STROBE_O)
  );

  // ----------------------------------------
  // Boot load
  // ----------------------------------------
  // Init sequence timer
  pulse_timer #(
    .LEN     (INIT_LEN)
  ) u_init (
    .clk_i   (CLK_I),
    .rstn_i  (RSTN_I),
    .start_i (boot_go_q), // RL5
    .pulse_o (INIT_SEQUENCE_O)
  );

  // Trailing edge sets processor 4 busy
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      boot_go_q      <= 1'b0;
      init_dly_q     <= 1'b0;
      SET_BUSY4_O    <= 1'b0;
      BOOT_PRIMARY_O <= 1'b0;
    end else begin
      boot_go_q      <= wr_cmd & AVS_WRITEDATA_I[`CMD_BOOT] & AVS_BYTEENABLE_I[0] & ~INIT_SEQUENCE_O;
      init_dly_q     <= INIT_SEQUENCE_O;
      SET_BUSY4_O    <= init_dly_q & ~INIT_SEQUENCE_O; // RL5
      BOOT_PRIMARY_O <= ctrl_q[`CTRL_PRIMARY]; // RL6
    end
  end

  // ----------------------------------------
  // Restart abort sequencing
  // ----------------------------------------
  // Load-time error events start the sequence
  assign abort_trig = ctrl_q[`CTRL_CS_LOAD] & (STAT_EVT_I[`ST_BURST_CHK] | STAT_EVT_I[`ST_END_CYL] |
                      STAT_EVT_I[`ST_NO_SYNC] | STAT_EVT_I[`ST_SEEK_INC]); // RL13

  // Lead phase carries the mask, pulse phase the abort
  always @* begin
    ab_d      = ab_q;
    ab_cnt_d  = ab_cnt_q;
    ab_hide_d = ab_hide_q;
    case (ab_q)
      AB_IDLE: begin
        if (abort_trig) begin
          ab_d      = AB_LEAD;
          ab_cnt_d  = ABORT_LEN - 4'h1;
          ab_hide_d = STAT_EVT_I[`ST_BURST_CHK] & ctrl_q[`CTRL_MAINT]; // RL7
        end
      end
      AB_LEAD: begin
        if (ab_cnt_q == 4'h0) begin
          ab_d     = AB_PULSE;
          ab_cnt_d = ABORT_LEN - 4'h1; // RL8
        end else begin
          ab_cnt_d = ab_cnt_q - 4'h1;
        end
      end
      AB_PULSE: begin
        if (ab_cnt_q == 4'h0) begin
          ab_d      = AB_IDLE;
          ab_hide_d = 1'b0;
        end else begin
          ab_cnt_d = ab_cnt_q - 4'h1; // RL13
        end
      end
      default: begin
        ab_d      = AB_IDLE;
        ab_cnt_d  = 4'h0;
        ab_hide_d = 1'b0;
      end
    endcase
  end

  // Sequencer registers and abort outputs
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ab_q                  <= AB_IDLE;
      ab_cnt_q              <= 4'h0;
      ab_hide_q             <= 1'b0;
      RESTART_ABORT_MASK_O  <= 1'b0;
      RESTART_ABORT_PULSE_O <= 1'b0;
    end else begin
      ab_q                  <= ab_d;
      ab_cnt_q              <= ab_cnt_d;
      ab_hide_q             <= ab_hide_d;
      RESTART_ABORT_MASK_O  <= (ab_d == AB_LEAD) & ab_hide_d; // RL8
      RESTART_ABORT_PULSE_O <= (ab_d == AB_PULSE); // RL13
    end
  end

  // ----------------------------------------
  // Time slice request
  // ----------------------------------------
  // Data and status requests drop on their own releases
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      req_data_q  <= 1'b0;
      req_stat_q  <= 1'b0;
      SLICE_REQ_O <= 1'b0;
    end else begin
      if (EXECUTE_PHASE_I) begin
        req_data_q <= 1'b0; // RL10
      end else if (wr_cmd && AVS_WRITEDATA_I[`CMD_REQ_DATA] && AVS_BYTEENABLE_I[0]) begin
        req_data_q <= 1'b1; // RL9
      end
      if (REQ_STATUS_DONE_I) begin
        req_stat_q <= 1'b0; // RL11
      end else if (wr_cmd && AVS_WRITEDATA_I[`CMD_REQ_STATUS] && AVS_BYTEENABLE_I[0]) begin
        req_stat_q <= 1'b1; // RL9
      end
      SLICE_REQ_O <= (req_data_q & ~EXECUTE_PHASE_I) | (req_stat_q & ~REQ_STATUS_DONE_I); // RL14
    end
  end

endmodule

`default_nettype wire

// [test/disc_adapter_assertions.sv]
// Concurrent checks on the disc adapter signalling outputs
`timescale 1ns/1ns
`default_nettype none
module disc_adapter_chk (
  input wire logic       CLK_I,
  input wire logic       RSTN_I,
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic       AVS_WRITE_I,
  input wire logic       AVS_WAITREQUEST_O,
  input wire logic [8:0] STAT_EVT_I,
  input wire logic       EXECUTE_PHASE_I,
  input wire logic       REQ_STATUS_DONE_I,
  input wire logic       DISC_WORD_STROBE_O,
  input wire logic       TRANSFER_END_O,
  input wire logic       XFER_EXIT_O,
  input wire logic       INIT_SEQUENCE_O,
  input wire logic       SET_BUSY4_O,
  input wire logic       RESTART_ABORT_MASK_O,
  input wire logic       RESTART_ABORT_PULSE_O,
  input wire logic       SLICE_REQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Completed status clear write
  wire clr_now = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 5'h04;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_strobe; $rose(DISC_WORD_STROBE_O) |-> DISC_WORD_STROBE_O[*4] ##1 !DISC_WORD_STROBE_O; endproperty
  property p_end; |STAT_EVT_I[5:0] |-> ##[1:2] TRANSFER_END_O; endproperty
  property p_exit; TRANSFER_END_O |-> XFER_EXIT_O; endproperty
  property p_hold; $fell(TRANSFER_END_O) |-> $past(clr_now) || $past(clr_now, 2); endproperty
  property p_init; $rose(INIT_SEQUENCE_O) |-> INIT_SEQUENCE_O[*8] ##1 !INIT_SEQUENCE_O; endproperty
  property p_busy; $fell(INIT_SEQUENCE_O) |-> ##[1:2] SET_BUSY4_O; endproperty
  property p_mask; $rose(RESTART_ABORT_MASK_O) |-> $past(STAT_EVT_I[6]) || $past(STAT_EVT_I[6], 2); endproperty
  property p_order;
    $rose(RESTART_ABORT_MASK_O) |-> RESTART_ABORT_MASK_O[*3] ##1 (!RESTART_ABORT_MASK_O && RESTART_ABORT_PULSE_O);
  endproperty
  property p_pulse; $rose(RESTART_ABORT_PULSE_O) |-> RESTART_ABORT_PULSE_O[*3]; endproperty
  property p_drop; SLICE_REQ_O && EXECUTE_PHASE_I |=> !SLICE_REQ_O; endproperty
  property p_keep; $fell(SLICE_REQ_O) |-> $past(EXECUTE_PHASE_I) || $past(REQ_STATUS_DONE_I); endproperty
  a_strobe: assert property (p_strobe) else $error("strobe width wrong");
  a_end: assert property (p_end) else $error("transfer end missing");
  a_exit: assert property (p_exit) else $error("exit not with end");
  a_hold: assert property (p_hold) else $error("transfer end fell uncleared");
  a_init: assert property (p_init) else $error("init sequence width wrong");
  a_busy: assert property (p_busy) else $error("busy set missing");
  a_mask: assert property (p_mask) else $error("mask without burst error");
  a_order: assert property (p_order) else $error("mask to pulse order wrong");
  a_pulse: assert property (p_pulse) else $error("abort pulse too short");
  a_drop: assert property (p_drop) else $error("slice kept after execute");
  a_keep: assert property (p_keep) else $error("slice dropped early");
  c_strobe: cover property ($rose(DISC_WORD_STROBE_O));
  c_abort: cover property ($rose(RESTART_ABORT_MASK_O));
  c_status: cover property (SLICE_REQ_O && REQ_STATUS_DONE_I);
endmodule
`default_nettype wire

// [test/time_slice_model.sv]
// Processor side model: slice grant, execute phase, status completion
`timescale 1ns/1ns
`default_nettype none
module time_slice_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        slice_i,
  input  wire logic        stat_i,
  input  wire logic        slow_i,
  input  wire logic        busy4_i,
  input  wire logic        primary_i,
  output var  logic        exec_o,
  output var  logic        done_o,
  output var  logic [15:0] csa_o
);
  logic       busy_q;
  logic [3:0] wait_q;
  // Grant after a short or long wait, then execute or finish status
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      exec_o <= 1'b0;
      done_o <= 1'b0;
      csa_o  <= 16'h0000;
    end else begin
      exec_o <= 1'b0;
      done_o <= 1'b0;
      if (busy4_i && primary_i) begin
        csa_o <= 16'h0113;
      end
      if (!busy_q && slice_i && !exec_o && !done_o) begin
        busy_q <= 1'b1;
        wait_q <= slow_i ? 4'hc : 4'h1;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        exec_o <= !stat_i;
        done_o <= stat_i;
      end
    end
  end
endmodule
`default_nettype wire

// [test/disc_adapter_processor_signalling_bench.sv]
// Self-checking bench for the disc adapter signalling block
`timescale 1ns/1ns
`default_nettype none
module disc_adapter_processor_signalling_bench;
  logic clk, rst_n, rd, wr, waitreq, irq, exec, sdone, cmp_eq, strobe, tend, xexit;
  logic init, busy4, prim, mask, pulse, slice, stat_mode, slow;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, x, w;
  logic [8:0]  evt;
  logic [15:0] ext, csa;
  logic [31:0] q [$];
  int err_total, compares, n;
  int cnt [5], base [5];
  disc_adapter u_disc_adapter (.CLK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .IRQ_O(irq), .STAT_EVT_I(evt), .EXECUTE_PHASE_I(exec),
    .REQ_STATUS_DONE_I(sdone), .CMP_EQUAL_I(cmp_eq), .EXT_DATA_O(ext), .DISC_WORD_STROBE_O(strobe),
    .TRANSFER_END_O(tend), .XFER_EXIT_O(xexit), .INIT_SEQUENCE_O(init), .SET_BUSY4_O(busy4),
    .BOOT_PRIMARY_O(prim), .RESTART_ABORT_MASK_O(mask), .RESTART_ABORT_PULSE_O(pulse), .SLICE_REQ_O(slice));
  time_slice_model u_time_slice_model (.clk_i(clk), .rst_n_i(rst_n), .slice_i(slice), .stat_i(stat_mode),
    .slow_i(slow), .busy4_i(busy4), .primary_i(prim), .exec_o(exec), .done_o(sdone), .csa_o(csa));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w1, input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w1;
    rd <= !w1;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdx(input logic [4:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic evt_pulse(input int b);
    evt <= 9'h001 << b;
    @(posedge clk);
    evt <= 9'h000;
    repeat (12) @(posedge clk);
  endtask
  // Read data compared against the oldest note
  always @(posedge clk) begin
    if (rd && waitreq === 1'b0 && q.size() > 0) chk(rdata, q.pop_front());
  end
  // High-cycle counters of the pulse outputs, sampled mid-cycle
  always @(negedge clk) begin
    cnt[0] += (strobe === 1'b1);
    cnt[1] += (init === 1'b1);
    cnt[2] += (busy4 === 1'b1);
    cnt[3] += (mask === 1'b1);
    cnt[4] += (pulse === 1'b1);
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, rd, wr, cmp_eq, stat_mode, slow} = 6'h00;
    addr = 5'h00;
    wdata = 32'h0;
    evt = 9'h000;
    x = 32'd78;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b1, 5'h18, 32'hffffffff);
    for (int a = 0; a < 7; a++) rdx(5'(a * 4), a == 5 ? 32'h20 : 32'h0);
    // Data word strobe, second write inside the pulse
    w = xs();
    base = cnt;
    bus(1'b1, 5'h0c, w);
    chk(32'(ext), 32'(w[15:0]));
    bus(1'b1, 5'h0c, ~w);
    repeat (8) @(posedge clk);
    chk(cnt[0] - base[0], 32'h4);
    rdx(5'h0c, {16'h0, ~w[15:0]});
    // Every transfer end cause, load command in normal mode
    bus(1'b1, 5'h08, 32'h1ff);
    bus(1'b1, 5'h00, 32'h2);
    for (int b = 0; b < 6; b++) begin
      evt_pulse(b);
      chk({tend, xexit, irq}, 3'h7);
      rdx(5'h04, 32'h1 << b);
      bus(1'b1, 5'h04, 32'h1 << b);
      repeat (2) @(posedge clk);
      chk({tend, irq}, 2'h0);
    end
    // Abort with mask in maintenance, without mask in normal mode
    base = cnt;
    bus(1'b1, 5'h00, 32'h3);
    evt_pulse(6);
    chk(cnt[3] - base[3], 32'h3);
    chk(cnt[4] - base[4], 32'h3);
    chk(32'(tend), 32'h0);
    base = cnt;
    bus(1'b1, 5'h08, 32'h0);
    bus(1'b1, 5'h00, 32'h2);
    evt_pulse(8);
    chk(cnt[3] - base[3], 32'h0);
    chk(cnt[4] - base[4], 32'h3);
    chk(32'(irq), 32'h0);
    rdx(5'h04, 32'h140);
    bus(1'b1, 5'h04, 32'h1ff);
    // Compare-equal and compare-unequal exits
    for (int k = 0; k < 2; k++) begin
      cmp_eq <= k[0];
      bus(1'b1, 5'h00, k ? 32'h28 : 32'h18);
      chk(32'(xexit), 32'h0);
      cmp_eq <= !k[0];
      repeat (2) @(posedge clk);
      chk(32'(xexit), 32'h1);
      repeat (2) @(posedge clk);
      rdx(5'h00, k ? 32'h20 : 32'h10);
    end
    // Boot with primary select, repeated boot ignored
    base = cnt;
    bus(1'b1, 5'h00, 32'h4);
    bus(1'b1, 5'h10, 32'h1);
    bus(1'b1, 5'h10, 32'h1);
    repeat (16) @(posedge clk);
    chk(cnt[1] - base[1], 32'h8);
    chk(cnt[2] - base[2], 32'h1);
    chk(32'(csa), 32'h0113);
    // Data and status slices, prompt and slow grant
    for (int m = 0; m < 4; m++) begin
      stat_mode <= m[0];
      slow <= m[1];
      bus(1'b1, 5'h10, m[0] ? 32'h4 : 32'h2);
      n = 0;
      while (slice !== 1'b1 && n < 8) begin
        @(posedge clk);
        n++;
      end
      chk(32'(slice), 32'h1);
      if (m[1]) rdx(5'h14, m[0] ? 32'h2a : 32'h26);
      n = 0;
      while (slice !== 1'b0 && n < 40) begin
        @(posedge clk);
        n++;
      end
      chk(32'(slice), 32'h0);
    end
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule
bind disc_adapter disc_adapter_chk u_disc_adapter_chk (.CLK_I, .RSTN_I, .AVS_ADDRESS_I, .AVS_WRITE_I,
  .AVS_WAITREQUEST_O, .STAT_EVT_I, .EXECUTE_PHASE_I, .REQ_STATUS_DONE_I, .DISC_WORD_STROBE_O,
  .TRANSFER_END_O, .XFER_EXIT_O, .INIT_SEQUENCE_O, .SET_BUSY4_O, .RESTART_ABORT_MASK_O,
  .RESTART_ABORT_PULSE_O, .SLICE_REQ_O);
`default_nettype wire
